// ### pll_wd_pkg.sv
// How it works
// RULE1: Four-bit ratio, 1..10 multiply, 0 bypass.
// RULE2: System clock is oscillator times ratio over n.
// RULE3: Watchdog off during ratio change, on after lock.
// RULE4: Ratio write forces bypass until lock.
// RULE5: Halver bypass zero on ratio write.
// RULE6: Ratio writes need protected write access.
// RULE7: Power off after ratio zero; direct clock.
// RULE8: Reset leaves bypass mode, PLL powered.
// RULE9: Lost oscillator gives limp clock.
// RULE10: Bypass routes limp clock automatically.
// RULE11: Watchdog holds on limp clock.
// RULE12: Clock failure resets device, sets flag.
// RULE13: Eight-bit counter, 512-cycle low pulse.
// RULE14: Key 0x55 then 0xAA clears counter.
// RULE15: Watchdog wake goes to low-power controller.
// RULE16: Standby stops all but the watchdog.
// RULE17: Idle wake raises interrupt via expander.
// RULE18: Halt stops watchdog count and wake.
// RULE19: Lock flag set after interval, cleared on write.
// RULE20: Reserved ratio codes behave as bypass.
package pll_wd_pkg;
  // ----------------------------------------------------------------
  // Device register indices.
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS    = 3'h0;
  localparam logic [2:0] ADDR_RATIO     = 3'h1;
  localparam logic [2:0] ADDR_WD_COUNT  = 3'h2;
  localparam logic [2:0] ADDR_WD_KEY    = 3'h3;
  localparam logic [2:0] ADDR_WD_CTRL   = 3'h4;
  // Status register bit positions.
  localparam int BIT_LOCK     = 0;
  localparam int BIT_HALVER   = 1;
  localparam int BIT_PLL_OFF  = 2;
  localparam int BIT_MISSING  = 3;
  localparam int BIT_LIMP     = 4;
  // Watchdog control bit positions.
  localparam int BIT_WD_DIS   = 0;
  localparam int BIT_WD_WAKE  = 1;
  // Ratio field and values.
  localparam int          RATIO_W     = 4;
  localparam logic [3:0]  RATIO_BYP   = 4'h0;
  localparam logic [3:0]  RATIO_MAX   = 4'hA;
  localparam logic [15:0] RATIO_RST   = 16'h0000;
  localparam logic [15:0] WD_CTRL_RST = 16'h0000;
  // Watchdog keys and timing.
  localparam logic [7:0]  KEY_ARM     = 8'h55;
  localparam logic [7:0]  KEY_CLEAR   = 8'hAA;
  localparam int          WD_W        = 8;
  localparam int          WD_PULSE_CYCLES = 512;
  localparam int          LOCK_CYCLES = 131072;
  // Low-power modes.
  localparam logic [1:0]  LPM_IDLE    = 2'h0;
  localparam logic [1:0]  LPM_STANDBY = 2'h1;
  // Controller register indices and command codes.
  localparam logic [1:0]  CREG_CMD    = 2'h0;
  localparam logic [1:0]  CREG_STAT   = 2'h1;
  localparam logic [2:0]  CMD_RATIO   = 3'h1;
  localparam logic [2:0]  CMD_KICK    = 3'h2;
  localparam logic [2:0]  CMD_PLL_OFF = 3'h3;
  localparam logic [2:0]  CMD_WD_CTRL = 3'h4;
  localparam int          CMD_ARG_LSB = 4;
  localparam int          CMD_OPT0    = 8;
  localparam int          CMD_OPT1    = 9;
  // Clock source selection.
  typedef enum logic [1:0] {SRC_OSC = 2'h0, SRC_PLL = 2'h1, SRC_LIMP = 2'h2} clk_src_t;
endpackage

// ### pll_wd_if.sv
interface pll_wd_if;
  import pll_wd_pkg::*;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        prot_we;
  // ----------------------------------------------------------------
  // Device end answers reads one cycle after rd.
  // ----------------------------------------------------------------
  modport device (input addr, input wdata, input wr, input rd, input prot_we, output rdata);
  modport ctrl   (output addr, output wdata, output wr, output rd, output prot_we, input rdata);
endinterface

// ### pll_wd_device.sv
module pll_wd_device
  import pll_wd_pkg::*;
#(
  parameter int LOCK_CNT = LOCK_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // Register link.
  pll_wd_if.device        bus,
  // Oscillator and power mode.
  input  wire logic       osc_present_i,
  input  wire logic       low_power_i,
  input  wire logic [1:0] lpm_mode_i,
  // Clock outputs.
  output clk_src_t        clk_src_o,
  output logic [3:0]      clk_mult_o,
  output logic [1:0]      clk_div_o,
  output logic            periph_run_o,
  // Resets and wakeups.
  output logic            device_reset_n_o,
  output logic            watchdog_reset_out_n_o,
  output logic            watchdog_wake_irq_o,
  output logic            lpm_wake_o,
  output logic            expander_irq_o
);
  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic [RATIO_W-1:0] ratio_reg;
  logic               halver_reg;
  logic               pll_off_reg;
  logic               lock_reg;
  logic [16:0]        lock_cnt_reg;
  logic               missing_reg;
  logic               seen_osc_reg;
  logic               limp_reg;
  logic               clk_fail_rst_reg;
  logic [WD_W-1:0]    wd_cnt_reg;
  logic               wd_dis_reg;
  logic               wd_wake_reg;
  logic               key_armed_reg;
  logic [9:0]         pulse_cnt_reg;
  logic               pulse_rst_reg;
  logic [15:0]        rdata_reg;

  logic ratio_wr;
  logic stat_wr;
  logic ctrl_wr;
  logic key_wr;
  logic fail_evt;
  logic halt_mode;
  logic wd_run;
  logic wd_top;

  // Ratio codes above ten are treated like bypass.
  function automatic logic ratio_valid(input logic [RATIO_W-1:0] r);
    ratio_valid = (r != RATIO_BYP) && (r <= RATIO_MAX); // see RULE1 see RULE20
  endfunction

  // Protected registers take writes only with protected access open.
  assign ratio_wr  = bus.wr && bus.prot_we && (bus.addr == ADDR_RATIO); // see RULE6
  assign stat_wr   = bus.wr && bus.prot_we && (bus.addr == ADDR_STATUS);
  assign ctrl_wr   = bus.wr && bus.prot_we && (bus.addr == ADDR_WD_CTRL);
  assign key_wr    = bus.wr && (bus.addr == ADDR_WD_KEY);
  assign halt_mode = low_power_i && lpm_mode_i[1];
  // Oscillator loss after it was once seen, with the PLL powered.
  assign fail_evt  = seen_osc_reg && !osc_present_i && !pll_off_reg && !limp_reg; // see RULE9

  // ----------------------------------------------------------------
  // Clock configuration.
  // ----------------------------------------------------------------
  // Ratio, halver and power-off; a clock failure restores defaults.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || fail_evt) begin
      ratio_reg   <= RATIO_RST[RATIO_W-1:0]; // see RULE8 see RULE12
      halver_reg  <= 1'b0;
      pll_off_reg <= 1'b0;
    end else begin
      if (ratio_wr) begin
        ratio_reg <= bus.wdata[RATIO_W-1:0];
      end
      if (stat_wr) begin
        halver_reg  <= bus.wdata[BIT_HALVER];
        pll_off_reg <= bus.wdata[BIT_PLL_OFF]; // see RULE7
      end
    end
  end

  // Lock timer counts oscillator cycles after each ratio write.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || fail_evt) begin
      lock_reg     <= 1'b0;
      lock_cnt_reg <= '0;
    end else if (ratio_wr) begin
      lock_reg     <= 1'b0; // see RULE19
      lock_cnt_reg <= 17'(LOCK_CNT - 1);
    end else if (!lock_reg && lock_cnt_reg != '0 && osc_present_i && !pll_off_reg) begin
      lock_cnt_reg <= lock_cnt_reg - 17'd1;
    end else if (!lock_reg && lock_cnt_reg == '0 && osc_present_i && !pll_off_reg) begin
      lock_reg <= 1'b1; // see RULE19
    end
  end

  // Clock source: bypass until lock, limp on loss, direct when off.
  always_comb begin
    if (limp_reg) begin
      clk_src_o  = SRC_LIMP; // see RULE10
      clk_mult_o = 4'h1;
    end else if (!pll_off_reg && lock_reg && ratio_valid(ratio_reg)) begin
      clk_src_o  = SRC_PLL; // see RULE4
      clk_mult_o = ratio_reg;
    end else begin
      clk_src_o  = SRC_OSC; // see RULE7 see RULE20
      clk_mult_o = 4'h1;
    end
    clk_div_o    = halver_reg ? 2'd1 : 2'd2; // see RULE2
    periph_run_o = !low_power_i || (lpm_mode_i == LPM_IDLE); // see RULE16
  end

  // ----------------------------------------------------------------
  // Missing clock detection.
  // ----------------------------------------------------------------
  // Limp mode lasts until reset; the flag survives the self reset.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      seen_osc_reg     <= 1'b0;
      limp_reg         <= 1'b0;
      missing_reg      <= 1'b0;
      clk_fail_rst_reg <= 1'b0;
    end else begin
      seen_osc_reg     <= seen_osc_reg || osc_present_i;
      clk_fail_rst_reg <= fail_evt; // see RULE12
      if (fail_evt) begin
        limp_reg <= 1'b1; // see RULE9
      end
      // A new failure wins over a clear in the same cycle.
      if (fail_evt) begin
        missing_reg <= 1'b1; // see RULE12
      end else if (stat_wr && bus.wdata[BIT_MISSING]) begin
        missing_reg <= 1'b0;
      end
    end
  end

  assign device_reset_n_o = !clk_fail_rst_reg;

  // ----------------------------------------------------------------
  // Watchdog.
  // ----------------------------------------------------------------
  // Counts on the live oscillator only, also in standby, not in halt.
  assign wd_run = !wd_dis_reg && osc_present_i && !limp_reg && !halt_mode; // see RULE11 see RULE18 see RULE16
  assign wd_top = wd_run && (wd_cnt_reg == {WD_W{1'b1}});

  // Control register.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || fail_evt) begin
      wd_dis_reg  <= WD_CTRL_RST[BIT_WD_DIS];
      wd_wake_reg <= WD_CTRL_RST[BIT_WD_WAKE];
    end else if (ctrl_wr) begin
      wd_dis_reg  <= bus.wdata[BIT_WD_DIS];
      wd_wake_reg <= bus.wdata[BIT_WD_WAKE];
    end
  end

  // Key sequence: 0x55 arms, 0xAA then clears and disarms; other values leave the arming unchanged.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || fail_evt) begin
      key_armed_reg <= 1'b0;
    end else if (key_wr) begin
      key_armed_reg <= (bus.wdata[7:0] == KEY_ARM) || (key_armed_reg && bus.wdata[7:0] != KEY_CLEAR); // see RULE14
    end
  end

  // Up counter, cleared by a completed key sequence.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || fail_evt) begin
      wd_cnt_reg <= '0;
    end else if (key_wr && key_armed_reg && bus.wdata[7:0] == KEY_CLEAR) begin
      wd_cnt_reg <= '0; // see RULE14
    end else if (wd_run) begin
      wd_cnt_reg <= wd_cnt_reg + 8'd1; // see RULE13
    end
  end

  // Output pulse of 512 oscillator cycles on reaching the maximum.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pulse_cnt_reg <= '0;
      pulse_rst_reg <= 1'b0;
    end else if (wd_top && pulse_cnt_reg == '0) begin
      pulse_cnt_reg <= 10'(WD_PULSE_CYCLES); // see RULE13
      pulse_rst_reg <= !wd_wake_reg;
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 10'd1;
    end
  end

  // Wake routing: standby to the low-power controller, idle to the expander.
  always_comb begin
    watchdog_reset_out_n_o = !(pulse_cnt_reg != '0 && pulse_rst_reg); // see RULE13
    watchdog_wake_irq_o    = pulse_cnt_reg != '0 && !pulse_rst_reg && !halt_mode; // see RULE18
    lpm_wake_o             = watchdog_wake_irq_o && low_power_i && lpm_mode_i == LPM_STANDBY; // see RULE15
    expander_irq_o         = watchdog_wake_irq_o && !(low_power_i && lpm_mode_i != LPM_IDLE); // see RULE17
  end

  // ----------------------------------------------------------------
  // Read port.
  // ----------------------------------------------------------------
  // Read data stand in the cycle after the read strobe.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_STATUS:   rdata_reg <= 16'({limp_reg, missing_reg, pll_off_reg, halver_reg, lock_reg});
        ADDR_RATIO:    rdata_reg <= 16'(ratio_reg);
        ADDR_WD_COUNT: rdata_reg <= 16'(wd_cnt_reg);
        ADDR_WD_CTRL:  rdata_reg <= 16'({wd_wake_reg, wd_dis_reg});
        default:       rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign bus.rdata = rdata_reg;
endmodule // pll_wd_device

// ### pll_wd_ctrl.sv
module pll_wd_ctrl
  import pll_wd_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Software port.
  input  wire logic [1:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // Device link.
  pll_wd_if.ctrl           dev
);
  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001, ST_WD_OFF = 11'h002, ST_HALV0  = 11'h004,
    ST_RATIO   = 11'h008, ST_POLL   = 11'h010, ST_POLL_W = 11'h020,
    ST_HALV1   = 11'h040, ST_WD_ON  = 11'h080, ST_KEY55  = 11'h100,
    ST_KEYAA   = 11'h200, ST_OFF    = 11'h400
  } state_t;

  state_t      state_reg;
  logic [3:0]  ratio_reg;
  logic        halver_reg;
  logic        off_req_reg;
  logic [1:0]  wd_ctrl_reg;
  logic [4:0]  dstat_reg;
  logic        rd_q_reg;
  logic [15:0] rdata_reg;
  logic        cmd_wr;
  logic [2:0]  cmd;

  assign cmd    = wdata_i[2:0];
  assign cmd_wr = wr_i && addr_i == CREG_CMD && state_reg == ST_IDLE;

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  // Ratio change: watchdog off, halver 0, ratio, wait lock, halver, watchdog back.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_reg   <= ST_IDLE;
      ratio_reg   <= '0;
      halver_reg  <= 1'b0;
      off_req_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_wr && cmd == CMD_RATIO) begin
            ratio_reg   <= wdata_i[CMD_ARG_LSB +: 4];
            halver_reg  <= wdata_i[CMD_OPT0];
            off_req_reg <= 1'b0;
            state_reg   <= ST_WD_OFF; // see RULE3
          end else if (cmd_wr && cmd == CMD_PLL_OFF) begin
            ratio_reg   <= RATIO_BYP; // see RULE7
            halver_reg  <= wdata_i[CMD_OPT0];
            off_req_reg <= 1'b1;
            state_reg   <= ST_HALV0;
          end else if (cmd_wr && cmd == CMD_KICK) begin
            state_reg <= ST_KEY55;
          end
        end
        ST_WD_OFF: state_reg <= ST_HALV0;
        ST_HALV0:  state_reg <= ST_RATIO;
        ST_RATIO:  state_reg <= off_req_reg ? ST_OFF : ST_POLL;
        ST_POLL:   state_reg <= ST_POLL_W;
        ST_POLL_W: state_reg <= dev.rdata[BIT_LOCK] ? ST_HALV1 : ST_POLL; // see RULE5
        ST_HALV1:  state_reg <= ST_WD_ON;
        ST_WD_ON:  state_reg <= ST_IDLE;
        ST_KEY55:  state_reg <= ST_KEYAA;
        ST_KEYAA:  state_reg <= ST_IDLE;
        ST_OFF:    state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Watchdog control shadow, written to the device by command.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wd_ctrl_reg <= WD_CTRL_RST[1:0];
    end else if (cmd_wr && cmd == CMD_WD_CTRL) begin
      wd_ctrl_reg <= {wdata_i[CMD_OPT1], wdata_i[CMD_OPT0]};
    end
  end

  // ----------------------------------------------------------------
  // Link drive.
  // ----------------------------------------------------------------
  always_comb begin
    dev.addr    = ADDR_STATUS;
    dev.wdata   = '0;
    dev.wr      = 1'b0;
    dev.rd      = 1'b0;
    dev.prot_we = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        dev.rd = !(cmd_wr && cmd == CMD_WD_CTRL);
        if (cmd_wr && cmd == CMD_WD_CTRL) begin
          dev.addr    = ADDR_WD_CTRL;
          dev.wdata   = 16'({wdata_i[CMD_OPT1], wdata_i[CMD_OPT0]});
          dev.wr      = 1'b1;
          dev.prot_we = 1'b1;
        end
      end
      ST_WD_OFF: begin
        dev.addr    = ADDR_WD_CTRL;
        dev.wdata   = 16'({wd_ctrl_reg[1], 1'b1}); // see RULE3
        dev.wr      = 1'b1;
        dev.prot_we = 1'b1;
      end
      ST_HALV0: begin
        dev.wdata   = '0; // see RULE5
        dev.wr      = 1'b1;
        dev.prot_we = 1'b1;
      end
      ST_RATIO: begin
        dev.addr    = ADDR_RATIO;
        dev.wdata   = 16'(ratio_reg); // see RULE7
        dev.wr      = 1'b1;
        dev.prot_we = 1'b1;
      end
      ST_POLL:   dev.rd = 1'b1;
      ST_POLL_W: dev.rd = 1'b0;
      ST_HALV1, ST_OFF: begin
        dev.wdata   = 16'({off_req_reg, halver_reg, 1'b0}); // see RULE5 see RULE7
        dev.wr      = 1'b1;
        dev.prot_we = 1'b1;
      end
      ST_WD_ON: begin
        dev.addr    = ADDR_WD_CTRL;
        dev.wdata   = 16'(wd_ctrl_reg); // see RULE3
        dev.wr      = 1'b1;
        dev.prot_we = 1'b1;
      end
      ST_KEY55, ST_KEYAA: begin
        dev.addr  = ADDR_WD_KEY;
        dev.wdata = 16'(state_reg == ST_KEY55 ? KEY_ARM : KEY_CLEAR); // see RULE14
        dev.wr    = 1'b1;
      end
      default: dev.rd = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Status and software read port.
  // ----------------------------------------------------------------
  // Device status captured from every status read answer.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rd_q_reg  <= 1'b0;
      dstat_reg <= '0;
    end else begin
      rd_q_reg <= dev.rd && dev.addr == ADDR_STATUS;
      if (rd_q_reg) begin
        dstat_reg <= dev.rdata[4:0];
      end
    end
  end

  // Read data in the cycle after the strobe.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else if (rd_i && addr_i == CREG_STAT) begin
      rdata_reg <= 16'({wd_ctrl_reg, dstat_reg, state_reg != ST_IDLE});
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;
endmodule // pll_wd_ctrl

// ### pll_wd_asserts.sv
module pll_wd_asserts
  import pll_wd_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  // Link signals between controller and device.
  input wire logic [2:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        prot_we
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // Lock tracking.
  // ----------------------------------------------------------------
  logic stat_rd_reg;
  logic lock_seen_reg;

  // Remembers whether a status read has shown lock since the last ratio write.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      stat_rd_reg   <= 1'b0;
      lock_seen_reg <= 1'b0;
    end else begin
      stat_rd_reg <= rd && addr == ADDR_STATUS;
      if (wr && addr == ADDR_RATIO) begin
        lock_seen_reg <= 1'b0;
      end else if (stat_rd_reg && rdata[BIT_LOCK]) begin
        lock_seen_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link checks.
  // ----------------------------------------------------------------
  sequence s_key_arm;
    wr && addr == ADDR_WD_KEY && wdata[7:0] == KEY_ARM;
  endsequence
  sequence s_key_clear;
    wr && addr == ADDR_WD_KEY && wdata[7:0] == KEY_CLEAR;
  endsequence
  sequence s_ratio_wr;
    wr && addr == ADDR_RATIO;
  endsequence

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_unmapped_read: assert property (rd && addr > ADDR_WD_CTRL |=> rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_one_strobe: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_ratio_prot: assert property (s_ratio_wr |-> prot_we)
    else $error("ratio write without protected access");
  a_key_pair: assert property (s_key_arm |=> s_key_clear)
    else $error("arm key not followed by clear key");
  a_ratio_halver: assert property (s_ratio_wr |-> $past(wr && addr == ADDR_STATUS && !wdata[BIT_HALVER]))
    else $error("ratio write without halver cleared first");
  a_ratio_wd_off: assert property ((s_ratio_wr and wdata[3:0] != 4'h0) |->
      $past(wr && addr == ADDR_WD_CTRL && wdata[BIT_WD_DIS], 2))
    else $error("ratio write with watchdog enabled");
  a_off_after_zero: assert property (wr && addr == ADDR_STATUS && wdata[BIT_PLL_OFF] |->
      $past(wr && addr == ADDR_RATIO && wdata == 16'h0000))
    else $error("power off without zero ratio first");
  a_halver_locked: assert property (wr && addr == ADDR_STATUS && wdata[BIT_HALVER] && !wdata[BIT_PLL_OFF] |->
      lock_seen_reg)
    else $error("halver set before lock was read");
endmodule // pll_wd_asserts

// ### tb_top.sv
module tb_top
  import pll_wd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------
  logic        clk_sys_i, rstn_i, wr_i, rd_i, osc_present_i, low_power_i;
  logic [1:0]  addr_i, lpm_mode_i, clk_div_o;
  logic [15:0] wdata_i, rdata_o, s;
  clk_src_t    clk_src_o, src_b;
  logic [3:0]  clk_mult_o;
  logic        periph_run_o, dev_rst_n, wd_rst_n, wake_irq, lpm_wake_o, exp_irq;
  int          err_total, checks_done, wd_falls, wake_rises, n, i;
  logic [4:0]  rr;

  pll_wd_if link();
  pll_wd_if link_b();
  pll_wd_ctrl i_pll_wd_ctrl (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dev(link));
  pll_wd_device #(.LOCK_CNT(16)) i_pll_wd_device (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(link),
    .osc_present_i(osc_present_i), .low_power_i(low_power_i), .lpm_mode_i(lpm_mode_i), .clk_src_o(clk_src_o),
    .clk_mult_o(clk_mult_o), .clk_div_o(clk_div_o), .periph_run_o(periph_run_o), .device_reset_n_o(dev_rst_n),
    .watchdog_reset_out_n_o(wd_rst_n), .watchdog_wake_irq_o(wake_irq), .lpm_wake_o(lpm_wake_o),
    .expander_irq_o(exp_irq));
  // Second device driven straight from the bench, to break the link rules on purpose.
  pll_wd_device #(.LOCK_CNT(16)) i_pll_wd_device_b (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(link_b),
    .osc_present_i(1'b1), .low_power_i(1'b0), .lpm_mode_i(LPM_IDLE), .clk_src_o(src_b), .clk_mult_o(),
    .clk_div_o(), .periph_run_o(), .device_reset_n_o(), .watchdog_reset_out_n_o(), .watchdog_wake_irq_o(),
    .lpm_wake_o(), .expander_irq_o());
  pll_wd_asserts i_pll_wd_asserts (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .prot_we(link.prot_we));

  // Clock and event counters for watchdog outputs.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge wd_rst_n) wd_falls++;
  always @(posedge wake_irq) wake_rises++;

  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand in the cycle after the strobe, so they are taken mid-cycle.
  task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_idle();
    s = 16'h0001;
    for (int k = 0; k < 100 && s[0] !== 1'b0; k++) sw_rd(CREG_STAT, s);
    chk("busy", 16'h0000, {15'h0000, s[0]});
  endtask
  task automatic cmd(input logic [15:0] d);
    sw_wr(CREG_CMD, d);
    wait_idle();
  endtask
  // Counts whole cycles until the level shows, sampled mid-cycle.
  task automatic wait_lvl(ref logic sig, input logic v, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(negedge clk_sys_i);
      if (sig === v) break;
    end
    @(posedge clk_sys_i);
  endtask
  task automatic chk_clk(input clk_src_t src, input logic [3:0] mult, input logic [1:0] div);
    chk("clk_src", 16'(src), 16'(clk_src_o));
    chk("clk_mult", 16'(mult), 16'(clk_mult_o));
    chk("clk_div", 16'(div), 16'(clk_div_o));
  endtask
  task automatic dev_wr(input logic [2:0] a, input logic [15:0] d, input logic p);
    link_b.addr <= a;
    link_b.wdata <= d;
    link_b.prot_we <= p;
    link_b.wr <= 1'b1;
    @(posedge clk_sys_i);
    link_b.wr <= 1'b0;
  endtask
  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask
  task automatic finish_test();
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog on the whole run.
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    addr_i = 2'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    osc_present_i = 1'b1;
    low_power_i = 1'b0;
    lpm_mode_i = LPM_IDLE;
    link_b.addr = 3'h0;
    link_b.wdata = 16'h0000;
    link_b.wr = 1'b0;
    link_b.rd = 1'b0;
    link_b.prot_we = 1'b0;
    do_reset();
    sw_rd(CREG_STAT, s);
    chk("stat", 16'h0000, s & 16'h003F);
    chk_clk(SRC_OSC, 4'h1, 2'h2);
    cmd(16'h0100 | 16'(CMD_WD_CTRL));
    // Unprotected ratio write is ignored, protected one locks; unmapped read gives zero.
    dev_wr(ADDR_RATIO, 16'h0005, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    chk("src_b", 16'(SRC_OSC), 16'(src_b));
    dev_wr(ADDR_RATIO, 16'h0005, 1'b1);
    repeat (30) @(posedge clk_sys_i);
    chk("src_b", 16'(SRC_PLL), 16'(src_b));
    link_b.addr <= 3'h7;
    link_b.rd <= 1'b1;
    @(posedge clk_sys_i);
    link_b.rd <= 1'b0;
    @(negedge clk_sys_i);
    chk("rdata_b", 16'h0000, link_b.rdata);
    @(posedge clk_sys_i);
    // Ratio codes 0 to 11, halver alternating; bypass while relocking.
    for (rr = 5'h00; rr < 5'h0C; rr++) begin
      sw_wr(CREG_CMD, {7'h00, rr[0], rr[3:0], 1'b0, CMD_RATIO});
      repeat (8) @(posedge clk_sys_i);
      chk_clk(SRC_OSC, 4'h1, 2'h2);
      wait_idle();
      if (rr >= 5'h01 && rr <= 5'h0A) chk_clk(SRC_PLL, rr[3:0], rr[0] ? 2'h1 : 2'h2);
      else chk_clk(SRC_OSC, 4'h1, rr[0] ? 2'h1 : 2'h2);
      sw_rd(CREG_STAT, s);
      chk("stat", 16'({rr[0], 2'b10}), s & 16'h003F);
    end
    // Periodic kicks hold off the pulse; then one 512-cycle pulse.
    cmd(16'(CMD_WD_CTRL));
    for (i = 0; i < 3; i++) begin
      repeat (150) @(posedge clk_sys_i);
      cmd(16'(CMD_KICK));
    end
    chk("wd_falls", 16'h0000, 16'(wd_falls));
    wait_lvl(wd_rst_n, 1'b0, 400, n);
    chk("wd_fall_time", 16'h0001, 16'(n > 230 && n < 260));
    wait_lvl(wd_rst_n, 1'b1, 600, n);
    // The sampling loop sees the rise one cycle short of the pulse width.
    chk("wd_pulse", 16'(WD_PULSE_CYCLES - 1), 16'(n));
    // Wake mode in standby, then idle, then halt.
    cmd(16'h0200 | 16'(CMD_WD_CTRL));
    low_power_i <= 1'b1;
    lpm_mode_i <= LPM_STANDBY;
    wait_lvl(wake_irq, 1'b1, 300, n);
    chk("periph_run", 16'h0000, 16'(periph_run_o));
    chk("lpm_wake", 16'h0001, {15'h0000, lpm_wake_o});
    lpm_mode_i <= LPM_IDLE;
    repeat (2) @(posedge clk_sys_i);
    chk("exp_irq", 16'h0001, {15'h0000, exp_irq});
    chk("lpm_wake", 16'h0000, {15'h0000, lpm_wake_o});
    lpm_mode_i <= 2'h2;
    wait_lvl(wake_irq, 1'b0, 600, n);
    i = wake_rises;
    repeat (800) @(posedge clk_sys_i);
    chk("halt_wake", 16'(i), 16'(wake_rises));
    low_power_i <= 1'b0;
    lpm_mode_i <= LPM_IDLE;
    // Oscillator loss: device reset, limp clock, flags, watchdog frozen.
    i = wd_falls;
    osc_present_i <= 1'b0;
    wait_lvl(dev_rst_n, 1'b0, 10, n);
    chk("dev_rst", 16'h0000, 16'(n > 5));
    chk("clk_src", 16'(SRC_LIMP), 16'(clk_src_o));
    repeat (600) @(posedge clk_sys_i);
    chk("wd_limp", 16'(i), 16'(wd_falls));
    sw_rd(CREG_STAT, s);
    chk("stat_fail", 16'h0030, s & 16'h0030);
    osc_present_i <= 1'b1;
    do_reset();
    // Power off with halver set.
    cmd(16'h0100 | 16'(CMD_PLL_OFF));
    chk_clk(SRC_OSC, 4'h1, 2'h1);
    sw_rd(CREG_STAT, s);
    chk("stat_off", 16'h000C, s & 16'h003F);
    finish_test();
  end
endmodule // tb_top
